/* rtl/mesh_radio_config_bank.sv */
// parameter bank of the mesh radio with its derived controls
`timescale 1ns/10ps
`include "mesh_radio_config_defs.svh"
module mesh_radio_config_bank #(
  parameter logic [15:0] FACTORY_TAG = 16'h1234, // value arbitrary
  parameter int KEY_W = 128
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_spi,
  input wire logic [4:0] req_sel,
  input wire logic [KEY_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [15:0] rsp_data,
  input wire logic [7:0] temp_sample,
  input wire logic factory_tags_en,
  input wire logic rx_preamble_valid,
  input wire logic [3:0] rx_preamble_group,
  input wire logic rx_header_valid,
  input wire logic [15:0] rx_header_tag,
  output logic rx_accept,
  output logic [15:0] network_tag_value,
  output logic [4:0] broadcast_tx_count,
  output logic [2:0] tx_power_setting,
  output logic unicast_ack_req,
  output logic [3:0] unicast_retry_max,
  output logic [5:0] broadcast_hops_used,
  output logic propagate_bcast_en,
  output logic route_relay_en,
  output logic mesh_ack_req,
  output logic [3:0] mesh_send_max,
  output logic route_repair_en,
  input wire logic rebc_start,
  input wire logic slot_tick,
  output logic rebc_go,
  output logic encrypt_enable,
  output logic [KEY_W-1:0] aes_key,
  output logic [7:0] rx_frame_type,
  input wire logic spi_active,
  output logic [1:0] serial_frame_mode,
  input wire logic [7:0] esc_byte,
  output logic esc_needed,
  input wire logic uart_rx_byte,
  input wire logic char_tick,
  input wire logic [8:0] packet_char_threshold,
  input wire logic [7:0] packet_silence_timeout,
  output logic pkt_start
);
  // ****************
  // parameter store
  // ****************
  logic [7:0] temp_q, temp_d;
  logic [3:0] pre_q, pre_d, rep_q, rep_d, urr_q, urr_d, slots_q, slots_d;
  logic [15:0] tag_q, tag_d;
  logic [2:0] pwr_q, pwr_d, mretry_q, mretry_d;
  logic [5:0] bhops_q, bhops_d;
  logic [4:0] nhops_q, nhops_d;
  logic [1:0] role_q, role_d, fmt_q, fmt_d, mode_q, mode_d;
  logic enc_q, enc_d;
  logic [KEY_W-1:0] key_q, key_d;
  logic rsp_valid_d, rsp_ok_d;
  logic [15:0] rsp_data_d;
  logic [15:0] wv;
  logic wr;
  logic in_range;

  assign wv = req_wdata[15:0];
  assign wr = req_valid && req_write;

  always_comb begin
    case (req_sel)
      `SEL_TEMPERATURE: in_range = 1'b0;
      `SEL_PREAMBLE: in_range = wv <= `MAX_PREAMBLE;
      `SEL_NET_TAG: in_range = (wv >= `MIN_NET_TAG && wv <= `MAX_NET_TAG) || wv == `FACTORY_SELECT_TAG;
      `SEL_BCAST_REPEAT: in_range = wv <= `MAX_NIBBLE;
      `SEL_TX_POWER: in_range = wv <= `MAX_TX_POWER;
      `SEL_UCAST_RETRY: in_range = wv <= `MAX_NIBBLE;
      `SEL_BCAST_HOPS: in_range = wv <= `MAX_BCAST_HOPS;
      `SEL_ROLE: in_range = wv == {14'h0000, `ROLE_ROUTER} || wv == {14'h0000, `ROLE_END_DEVICE};
      `SEL_MESH_RETRY: in_range = wv <= `MAX_MESH_RETRY;
      `SEL_NET_HOPS: in_range = wv >= `MIN_NET_HOPS && wv <= `MAX_NET_HOPS;
      `SEL_REBC_SLOTS: in_range = wv >= `MIN_REBC_SLOTS && wv <= `MAX_REBC_SLOTS;
      `SEL_ENCRYPT: in_range = wv <= 16'h0001;
      `SEL_KEY: in_range = 1'b1;
      `SEL_RX_FORMAT: in_range = wv <= `MAX_MODE;
      `SEL_FRAME_MODE: in_range = wv <= `MAX_MODE;
      default: in_range = 1'b0;
    endcase
  end

  always_comb begin
    temp_d = temp_sample;
    pre_d = pre_q;
    tag_d = tag_q;
    rep_d = rep_q;
    pwr_d = pwr_q;
    urr_d = urr_q;
    bhops_d = bhops_q;
    role_d = role_q;
    mretry_d = mretry_q;
    nhops_d = nhops_q;
    slots_d = slots_q;
    enc_d = enc_q;
    key_d = key_q;
    fmt_d = fmt_q;
    mode_d = mode_q;
    rsp_valid_d = req_valid;
    rsp_ok_d = 1'b0;
    rsp_data_d = 16'h0000;
    if (wr) begin
      rsp_ok_d = in_range;
      if (in_range) begin
        case (req_sel)
          `SEL_PREAMBLE: pre_d = wv[3:0];
          `SEL_NET_TAG: tag_d = wv;
          `SEL_BCAST_REPEAT: rep_d = wv[3:0];
          `SEL_TX_POWER: pwr_d = wv[2:0];
          `SEL_UCAST_RETRY: urr_d = wv[3:0];
          `SEL_BCAST_HOPS: bhops_d = wv[5:0];
          `SEL_ROLE: role_d = wv[1:0];
          `SEL_MESH_RETRY: mretry_d = wv[2:0];
          `SEL_NET_HOPS: nhops_d = wv[4:0];
          `SEL_REBC_SLOTS: slots_d = wv[3:0];
          `SEL_ENCRYPT: enc_d = wv[0];
          `SEL_KEY: key_d = req_wdata;
          `SEL_RX_FORMAT: fmt_d = wv[1:0];
          `SEL_FRAME_MODE: mode_d = req_spi ? mode_q : wv[1:0];
          default: mode_d = mode_q;
        endcase
      end
    end else if (req_valid) begin
      rsp_ok_d = req_sel <= `SEL_FRAME_MODE;
      case (req_sel)
        `SEL_TEMPERATURE: rsp_data_d = {8'h00, temp_q};
        `SEL_PREAMBLE: rsp_data_d = {12'h000, pre_q};
        `SEL_NET_TAG: rsp_data_d = tag_q;
        `SEL_BCAST_REPEAT: rsp_data_d = {12'h000, rep_q};
        `SEL_TX_POWER: rsp_data_d = {13'h0000, pwr_q};
        `SEL_UCAST_RETRY: rsp_data_d = {12'h000, urr_q};
        `SEL_BCAST_HOPS: rsp_data_d = {10'h000, bhops_q};
        `SEL_ROLE: rsp_data_d = {14'h0000, role_q};
        `SEL_MESH_RETRY: rsp_data_d = {13'h0000, mretry_q};
        `SEL_NET_HOPS: rsp_data_d = {11'h000, nhops_q};
        `SEL_REBC_SLOTS: rsp_data_d = {12'h000, slots_q};
        `SEL_ENCRYPT: rsp_data_d = {15'h0000, enc_q};
        `SEL_RX_FORMAT: rsp_data_d = {14'h0000, fmt_q};
        `SEL_FRAME_MODE: rsp_data_d = {14'h0000, serial_frame_mode};
        default: rsp_data_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      temp_q <= 8'h00;
      pre_q <= `RST_PREAMBLE;
      tag_q <= `RST_NET_TAG;
      rep_q <= `RST_BCAST_REPEAT;
      pwr_q <= `RST_TX_POWER;
      urr_q <= `RST_UCAST_RETRY;
      bhops_q <= `RST_BCAST_HOPS;
      role_q <= `RST_ROLE;
      mretry_q <= `RST_MESH_RETRY;
      nhops_q <= `RST_NET_HOPS;
      slots_q <= `RST_REBC_SLOTS;
      enc_q <= `RST_ENCRYPT;
      key_q <= '0;
      fmt_q <= `RST_RX_FORMAT;
      mode_q <= `RST_FRAME_MODE;
      rsp_valid <= 1'b0;
      rsp_ok <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      temp_q <= temp_d;
      pre_q <= pre_d;
      tag_q <= tag_d;
      rep_q <= rep_d;
      pwr_q <= pwr_d;
      urr_q <= urr_d;
      bhops_q <= bhops_d;
      role_q <= role_d;
      mretry_q <= mretry_d;
      nhops_q <= nhops_d;
      slots_q <= slots_d;
      enc_q <= enc_d;
      key_q <= key_d;
      fmt_q <= fmt_d;
      mode_q <= mode_d;
      rsp_valid <= rsp_valid_d;
      rsp_ok <= rsp_ok_d;
      rsp_data <= rsp_data_d;
    end
  end

  // ****************
  // derived controls
  // ****************
  always_comb begin
    network_tag_value = (factory_tags_en && tag_q == `FACTORY_SELECT_TAG) ? FACTORY_TAG : tag_q;
    broadcast_tx_count = {1'b0, rep_q} + 5'h01;
    unicast_ack_req = urr_q != 4'h0;
    broadcast_hops_used = (bhops_q > {1'b0, nhops_q}) ? {1'b0, nhops_q} : bhops_q;
    propagate_bcast_en = role_q != `ROLE_END_DEVICE;
    route_relay_en = role_q != `ROLE_END_DEVICE;
    mesh_ack_req = mretry_q != 3'h0;
    mesh_send_max = (mretry_q == 3'h0) ? 4'h1 : {1'b0, mretry_q} + 4'h1;
    route_repair_en = mretry_q != 3'h0;
    serial_frame_mode = spi_active ? `MODE_FRAMED : mode_q;
    esc_needed = serial_frame_mode == `MODE_ESCAPED && (esc_byte == `BYTE_XON || esc_byte == `BYTE_XOFF ||
      esc_byte == `BYTE_ESC || esc_byte == `BYTE_DELIM);
    case (fmt_q)
      `FMT_STD: rx_frame_type = `FRAME_STD;
      `FMT_EXPLICIT: rx_frame_type = `FRAME_EXPLICIT;
      default: rx_frame_type = `FRAME_LEGACY;
    endcase
  end
  assign tx_power_setting = pwr_q;
  assign unicast_retry_max = urr_q;
  assign encrypt_enable = enc_q;
  assign aes_key = key_q;

  // ****************
  // receive filter
  // ****************
  logic pre_pass_q, pre_pass_d, acc_q, acc_d;
  always_comb begin
    pre_pass_d = pre_pass_q;
    if (rx_preamble_valid) begin
      pre_pass_d = rx_preamble_group == pre_q;
    end
    acc_d = rx_header_valid && pre_pass_q && rx_header_tag == network_tag_value;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_pass_q <= 1'b0;
      acc_q <= 1'b0;
    end else begin
      pre_pass_q <= pre_pass_d;
      acc_q <= acc_d;
    end
  end
  assign rx_accept = acc_q;

  // ****************
  // rebroadcast delay
  // ****************
  mesh_radio_config_pkg::rebc_state_t rs_q, rs_d;
  logic [3:0] wait_q, wait_d;
  logic [7:0] lfsr_q, lfsr_d;
  logic go_q, go_d;
  always_comb begin
    lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    rs_d = rs_q;
    wait_d = wait_q;
    go_d = 1'b0;
    case (rs_q)
      mesh_radio_config_pkg::REBC_IDLE: begin
        if (rebc_start && propagate_bcast_en) begin
          rs_d = mesh_radio_config_pkg::REBC_WAIT;
          wait_d = (lfsr_q[3:0] % slots_q) + 4'h1;
        end
      end
      mesh_radio_config_pkg::REBC_WAIT: begin
        if (slot_tick) begin
          wait_d = wait_q - 4'h1;
          if (wait_q == 4'h1) begin
            go_d = 1'b1;
            rs_d = mesh_radio_config_pkg::REBC_IDLE;
          end
        end
      end
      default: rs_d = mesh_radio_config_pkg::REBC_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      rs_q <= mesh_radio_config_pkg::REBC_IDLE;
      wait_q <= 4'h0;
      lfsr_q <= 8'hA5;
      go_q <= 1'b0;
    end else begin
      rs_q <= rs_d;
      wait_q <= wait_d;
      lfsr_q <= lfsr_d;
      go_q <= go_d;
    end
  end
  assign rebc_go = go_q;

  // ****************
  // transparent packetizer
  // ****************
  logic [8:0] cnt_q, cnt_d;
  logic [7:0] sil_q, sil_d;
  logic pkt_q, pkt_d;
  always_comb begin
    cnt_d = cnt_q;
    sil_d = sil_q;
    pkt_d = 1'b0;
    if (serial_frame_mode != `MODE_TRANSPARENT) begin
      cnt_d = 9'h000;
      sil_d = 8'h00;
    end else if (uart_rx_byte) begin
      sil_d = 8'h00;
      if (cnt_q + 9'h001 >= packet_char_threshold) begin
        pkt_d = 1'b1;
        cnt_d = 9'h000;
      end else begin
        cnt_d = cnt_q + 9'h001;
      end
    end else if (char_tick && cnt_q != 9'h000 && packet_silence_timeout != 8'h00) begin
      if (sil_q + 8'h01 >= packet_silence_timeout) begin
        pkt_d = 1'b1;
        cnt_d = 9'h000;
        sil_d = 8'h00;
      end else begin
        sil_d = sil_q + 8'h01;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 9'h000;
      sil_q <= 8'h00;
      pkt_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sil_q <= sil_d;
      pkt_q <= pkt_d;
    end
  end
  assign pkt_start = pkt_q;

  // ****************
  // assertions
  // ****************
  AST_PREAMBLE_FIRST: assert property (@(posedge clk) disable iff (reset)
    rx_header_valid && !pre_pass_q |=> !rx_accept) else $error("accept without preamble match");
  AST_BCAST_COUNT: assert property (@(posedge clk) disable iff (reset)
    broadcast_tx_count == {1'b0, rep_q} + 5'h01) else $error("broadcast count wrong");
  AST_HOPS_MIN: assert property (@(posedge clk) disable iff (reset)
    broadcast_hops_used <= bhops_q && broadcast_hops_used <= {1'b0, nhops_q} &&
    (broadcast_hops_used == bhops_q || broadcast_hops_used == {1'b0, nhops_q}))
    else $error("hop limit not minimum");
  AST_END_DEVICE: assert property (@(posedge clk) disable iff (reset)
    role_q == `ROLE_END_DEVICE |-> !propagate_bcast_en && !route_relay_en) else $error("end device relays");
  AST_MESH_OFF: assert property (@(posedge clk) disable iff (reset)
    mretry_q == 3'h0 |-> !mesh_ack_req && !route_repair_en) else $error("mesh ack with zero retries");
  AST_KEY_HIDDEN: assert property (@(posedge clk) disable iff (reset)
    req_valid && !req_write && req_sel == `SEL_KEY |=> rsp_valid && rsp_ok && rsp_data == 16'h0000)
    else $error("key read leaked");
  AST_SPI_MODE: assert property (@(posedge clk) disable iff (reset)
    wr && req_spi && req_sel == `SEL_FRAME_MODE |=> $stable(mode_q)) else $error("spi changed frame mode");
  AST_RANGE_REJECT: assert property (@(posedge clk) disable iff (reset)
    wr && req_sel == `SEL_PREAMBLE && wv > `MAX_PREAMBLE |=> !rsp_ok && $stable(pre_q))
    else $error("out of range write taken");
  AST_REBC_BOUND: assert property (@(posedge clk) disable iff (reset)
    rs_q == mesh_radio_config_pkg::REBC_WAIT |-> wait_q >= 4'h1 && wait_q <= slots_q)
    else $error("rebroadcast wait out of bound");
  AST_FORMAT: assert property (@(posedge clk) disable iff (reset)
    fmt_q == `FMT_EXPLICIT |-> rx_frame_type == `FRAME_EXPLICIT) else $error("frame type mismatch");
endmodule // mesh_radio_config_bank

/* rtl/mesh_radio_config_defs.svh */
// constants of the mesh radio parameter bank
//
// What this block does
// - temperature reads back as signed 8-bit whole degrees, read-only.
// - preamble group 0..9, reset 0; accept only packets with equal group.
// - preamble group is checked first, network tag afterwards.
// - network tag 16 bits, reset 0x3332, settable 0x10..0x7FFF, must match.
// - with factory tags enabled, setting 0xFFFF selects the factory value.
// - each broadcast goes out repeat count plus one times; 0..0xF, reset 3.
// - transmit power 0..4, reset 4, selects the conducted level.
// - nonzero unicast retry limit requests an acknowledgment per unicast.
// - unicast resent at most retry limit times; range 0..0xF, reset 0xA.
// - broadcast hops used is min of broadcast and network hops; 0..0x20.
// - role 0 router, 2 end device; end device neither propagates nor relays.
// - mesh retry zero disables network acks and route repair.
// - rebroadcast waits random slots up to maximum 1..0xA, reset 3.
// - one-bit encryption enable, reset 0.
// - 128-bit key is write-only; a read answers OK only.
// - receive format 0 gives 0x90, 1 gives 0x91, 2 gives 0x80; reset 2.
// - frame mode 0 transparent, 1 framed, 2 framed with escapes; reset 0.
// - escaped framing escapes bytes 0x11, 0x13, 0x7D and 0x7E.
// - over SPI frame mode writes are ignored; mode is framed without escapes.
// - transparent mode delimits packets by character count and silence.
// - send on count threshold, or on silence after at least one byte.
`ifndef MESH_RADIO_CONFIG_DEFS_SVH
`define MESH_RADIO_CONFIG_DEFS_SVH

`define SEL_TEMPERATURE 5'h00
`define SEL_PREAMBLE 5'h01
`define SEL_NET_TAG 5'h02
`define SEL_BCAST_REPEAT 5'h03
`define SEL_TX_POWER 5'h04
`define SEL_UCAST_RETRY 5'h05
`define SEL_BCAST_HOPS 5'h06
`define SEL_ROLE 5'h07
`define SEL_MESH_RETRY 5'h08
`define SEL_NET_HOPS 5'h09
`define SEL_REBC_SLOTS 5'h0A
`define SEL_ENCRYPT 5'h0B
`define SEL_KEY 5'h0C
`define SEL_RX_FORMAT 5'h0D
`define SEL_FRAME_MODE 5'h0E

`define RST_PREAMBLE 4'h0
`define RST_NET_TAG 16'h3332
`define RST_BCAST_REPEAT 4'h3
`define RST_TX_POWER 3'h4
`define RST_UCAST_RETRY 4'hA
`define RST_BCAST_HOPS 6'h00
`define RST_ROLE 2'h0
`define RST_MESH_RETRY 3'h1
`define RST_NET_HOPS 5'h07
`define RST_REBC_SLOTS 4'h3
`define RST_ENCRYPT 1'h0
`define RST_RX_FORMAT 2'h2
`define RST_FRAME_MODE 2'h0

`define MAX_PREAMBLE 16'h0009
`define MIN_NET_TAG 16'h0010
`define MAX_NET_TAG 16'h7FFF
`define FACTORY_SELECT_TAG 16'hFFFF
`define MAX_NIBBLE 16'h000F
`define MAX_TX_POWER 16'h0004
`define MAX_BCAST_HOPS 16'h0020
`define ROLE_ROUTER 2'h0
`define ROLE_END_DEVICE 2'h2
`define MAX_MESH_RETRY 16'h0007
`define MIN_NET_HOPS 16'h0001
`define MAX_NET_HOPS 16'h0014
`define MIN_REBC_SLOTS 16'h0001
`define MAX_REBC_SLOTS 16'h000A
`define MAX_MODE 16'h0002

`define FMT_STD 2'h0
`define FMT_EXPLICIT 2'h1
`define FRAME_STD 8'h90
`define FRAME_EXPLICIT 8'h91
`define FRAME_LEGACY 8'h80

`define MODE_TRANSPARENT 2'h0
`define MODE_FRAMED 2'h1
`define MODE_ESCAPED 2'h2

`define BYTE_XON 8'h11
`define BYTE_XOFF 8'h13
`define BYTE_ESC 8'h7D
`define BYTE_DELIM 8'h7E

`endif

/* rtl/mesh_radio_config_pkg.sv */
// types of the mesh radio parameter bank
package mesh_radio_config_pkg;
  typedef enum logic [0:0] {REBC_IDLE, REBC_WAIT} rebc_state_t;
endpackage

/* testbench/cfg_host.sv */
// host model that issues parameter commands to the bank
`timescale 1ns/10ps
module cfg_host (
  input wire logic clk,
  output logic req_valid,
  output logic req_write,
  output logic req_spi,
  output logic [4:0] req_sel,
  output logic [127:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic [15:0] rsp_data
);
  // ****************************************
  // command issue
  // ****************************************
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_spi = 1'b0;
    req_sel = 5'h00;
    req_wdata = '0;
  end

  // entered just after an edge; leaves one edge after the answer
  task automatic cmd(input logic w, input logic sp, input logic [4:0] s, input logic [127:0] d,
                     output logic ok, output logic [15:0] q, output logic to);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = w;
    req_spi = sp;
    req_sel = s;
    req_wdata = d;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    // released lines do not keep the old value
    req_sel = ~s;
    req_wdata = ~d;
    while (rsp_valid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    to = (n == 4);
    ok = rsp_ok;
    q = rsp_data;
    @(posedge clk);
    #1;
  endtask
endmodule // cfg_host

/* testbench/tb_top.sv */
// self-checking bench of the mesh radio parameter bank
`timescale 1ns/10ps
module tb_top;
  localparam logic [15:0] FTAG = 16'h2A5C; // value arbitrary
  localparam logic [127:0] KEYV = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  logic clk, reset, req_valid, req_write, req_spi, rsp_valid, rsp_ok, ok, to, spi_cmd;
  logic [4:0] req_sel, broadcast_tx_count;
  logic [127:0] req_wdata, aes_key;
  logic [15:0] rsp_data, rx_header_tag, network_tag_value, q;
  logic [7:0] temp_sample, rx_frame_type, esc_byte, packet_silence_timeout;
  logic factory_tags_en, rx_preamble_valid, rx_header_valid, rx_accept, unicast_ack_req;
  logic [3:0] rx_preamble_group, unicast_retry_max, mesh_send_max;
  logic [2:0] tx_power_setting;
  logic [5:0] broadcast_hops_used;
  logic propagate_bcast_en, route_relay_en, mesh_ack_req, route_repair_en, rebc_start, slot_tick;
  logic rebc_go, encrypt_enable, spi_active, esc_needed, uart_rx_byte, char_tick, pkt_start;
  logic [1:0] serial_frame_mode;
  logic [8:0] packet_char_threshold;
  int failures = 0;
  int samples_checked = 0;
  int n;
  logic [4:0] rs [13] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A,
                          5'h0B, 5'h0D, 5'h0E};
  logic [15:0] rv [13] = '{16'h0000, 16'h3332, 16'h0003, 16'h0004, 16'h000A, 16'h0000, 16'h0000,
                           16'h0001, 16'h0007, 16'h0003, 16'h0000, 16'h0002, 16'h0000};
  // selector, legal value, refused value
  logic [39:0] rt [16] = '{40'h01_0009_000A, 40'h03_000F_0010, 40'h04_0004_0005, 40'h05_000F_0010,
                           40'h06_0020_0021, 40'h07_0002_0001, 40'h08_0007_0008, 40'h09_0001_0000,
                           40'h09_0014_0015, 40'h0A_0001_0000, 40'h0A_000A_000B, 40'h0B_0001_0002,
                           40'h0D_0002_0003, 40'h0E_0002_0003, 40'h02_0010_000F, 40'h02_7FFF_8000};
  logic [7:0] eb [5] = '{8'h12, 8'h11, 8'h13, 8'h7D, 8'h7E};

  mesh_radio_config_bank #(.FACTORY_TAG(FTAG), .KEY_W(128)) mesh_radio_config_bank_inst (
    .clk, .reset, .req_valid, .req_write, .req_spi, .req_sel, .req_wdata, .rsp_valid, .rsp_ok,
    .rsp_data, .temp_sample, .factory_tags_en, .rx_preamble_valid, .rx_preamble_group,
    .rx_header_valid, .rx_header_tag, .rx_accept, .network_tag_value, .broadcast_tx_count,
    .tx_power_setting, .unicast_ack_req, .unicast_retry_max, .broadcast_hops_used,
    .propagate_bcast_en, .route_relay_en, .mesh_ack_req, .mesh_send_max, .route_repair_en,
    .rebc_start, .slot_tick, .rebc_go, .encrypt_enable, .aes_key, .rx_frame_type, .spi_active,
    .serial_frame_mode, .esc_byte, .esc_needed, .uart_rx_byte, .char_tick, .packet_char_threshold,
    .packet_silence_timeout, .pkt_start);

  cfg_host cfg_host_inst (.clk, .req_valid, .req_write, .req_spi, .req_sel, .req_wdata, .rsp_valid,
    .rsp_ok, .rsp_data);

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task results;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [127:0] g, input logic [127:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task step;
    @(posedge clk);
    #1;
  endtask

  task cmd(input logic w, input logic [4:0] s, input logic [127:0] d);
    cfg_host_inst.cmd(w, spi_cmd, s, d, ok, q, to);
    if (to) begin
      failures++;
      results();
    end
  endtask

  task wr(input logic [4:0] s, input logic [127:0] d, input logic e);
    cmd(1'b1, s, d);
    chk(ok, e);
  endtask

  task rd(input logic [4:0] s, input logic [15:0] e);
    cmd(1'b0, s, '0);
    chk(ok, 1'b1);
    chk(q, e);
  endtask

  task rx(input logic [3:0] g, input logic [15:0] t, input logic e);
    rx_preamble_valid = 1'b1;
    rx_preamble_group = g;
    step;
    rx_preamble_valid = 1'b0;
    rx_preamble_group = ~g;
    rx_header_valid = 1'b1;
    rx_header_tag = t;
    step;
    rx_header_valid = 1'b0;
    rx_header_tag = ~t;
    chk(rx_accept, e);
  endtask

  task rebc(input logic must);
    rebc_start = 1'b1;
    step;
    rebc_start = 1'b0;
    slot_tick = 1'b1;
    n = 0;
    while (rebc_go !== 1'b1 && n < 12) begin
      step;
      n++;
    end
    slot_tick = 1'b0;
    step;
    if (must && n == 12) begin
      failures++;
      results();
    end
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {reset, spi_cmd, factory_tags_en, rx_preamble_valid, rx_header_valid, rebc_start} = 6'h20;
    {slot_tick, spi_active, uart_rx_byte, char_tick} = 4'h0;
    {rx_preamble_group, rx_header_tag, esc_byte, packet_char_threshold} = 37'h0;
    temp_sample = 8'hF6;
    packet_silence_timeout = 8'h00;
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 13; i++) rd(rs[i], rv[i]);
    chk(broadcast_tx_count, 5'h04);
    chk(rx_frame_type, 8'h80);
    chk(mesh_send_max, 4'h2);
    $display("test reset_values done");
    cmd(1'b0, 5'h00, '0);
    chk(q[7:0], 8'hF6);
    wr(5'h00, 16'h0005, 1'b0);
    wr(5'h1F, 16'h0001, 1'b0);
    cmd(1'b0, 5'h1F, '0);
    chk(ok, 1'b0);
    for (int i = 0; i < 16; i++) begin
      wr(rt[i][36:32], rt[i][31:16], 1'b1);
      wr(rt[i][36:32], rt[i][15:0], 1'b0);
      rd(rt[i][36:32], rt[i][31:16]);
    end
    chk(broadcast_tx_count, 5'h10);
    chk(tx_power_setting, 3'h4);
    chk({unicast_ack_req, unicast_retry_max}, 5'h1F);
    chk(broadcast_hops_used, 6'h14);
    chk({propagate_bcast_en, route_relay_en}, 2'h0);
    chk({mesh_ack_req, route_repair_en, mesh_send_max}, 6'h38);
    chk(encrypt_enable, 1'b1);
    chk(network_tag_value, 16'h7FFF);
    for (int i = 0; i < 5; i++) begin
      esc_byte = eb[i];
      step;
      chk(esc_needed, i != 0);
    end
    $display("test ranges done");
    wr(5'h05, 16'h0000, 1'b1);
    chk(unicast_ack_req, 1'b0);
    wr(5'h08, 16'h0000, 1'b1);
    chk({mesh_ack_req, route_repair_en, mesh_send_max}, 6'h01);
    wr(5'h06, 16'h0003, 1'b1);
    chk(broadcast_hops_used, 6'h03);
    wr(5'h04, 16'h0000, 1'b1);
    chk(tx_power_setting, 3'h0);
    wr(5'h03, 16'h0000, 1'b1);
    chk(broadcast_tx_count, 5'h01);
    wr(5'h07, 16'h0000, 1'b1);
    chk({propagate_bcast_en, route_relay_en}, 2'h3);
    for (int i = 0; i < 2; i++) begin
      wr(5'h0D, i, 1'b1);
      chk(rx_frame_type, i ? 8'h91 : 8'h90);
    end
    spi_cmd = 1'b1;
    wr(5'h0E, 16'h0000, 1'b1);
    spi_cmd = 1'b0;
    rd(5'h0E, 16'h0002);
    spi_active = 1'b1;
    step;
    chk({serial_frame_mode, esc_needed}, 3'h2);
    spi_active = 1'b0;
    wr(5'h0E, 16'h0001, 1'b1);
    chk(esc_needed, 1'b0);
    wr(5'h0E, 16'h0000, 1'b1);
    chk(serial_frame_mode, 2'h0);
    wr(5'h0C, KEYV, 1'b1);
    chk(aes_key, KEYV);
    rd(5'h0C, 16'h0000);
    $display("test modes done");
    factory_tags_en = 1'b1;
    wr(5'h02, 16'hFFFF, 1'b1);
    chk(network_tag_value, FTAG);
    wr(5'h02, 16'h0ABC, 1'b1);
    wr(5'h01, 16'h0005, 1'b1);
    rx(4'h5, 16'h0ABC, 1'b1);
    rx(4'h4, 16'h0ABC, 1'b0);
    rx(4'h5, 16'h0ABD, 1'b0);
    $display("test receive done");
    wr(5'h0A, 16'h0001, 1'b1);
    rebc(1'b1);
    chk(n, 1);
    wr(5'h0A, 16'h0003, 1'b1);
    rebc(1'b1);
    chk(n >= 1 && n <= 3, 1'b1);
    wr(5'h07, 16'h0002, 1'b1);
    rebc(1'b0);
    chk(n, 12);
    $display("test rebroadcast done");
    packet_char_threshold = 9'h003;
    uart_rx_byte = 1'b1;
    step;
    chk(pkt_start, 1'b0);
    step;
    chk(pkt_start, 1'b0);
    step;
    uart_rx_byte = 1'b0;
    chk(pkt_start, 1'b1);
    step;
    packet_char_threshold = 9'h009;
    packet_silence_timeout = 8'h02;
    uart_rx_byte = 1'b1;
    step;
    uart_rx_byte = 1'b0;
    char_tick = 1'b1;
    step;
    chk(pkt_start, 1'b0);
    step;
    char_tick = 1'b0;
    chk(pkt_start, 1'b1);
    $display("test packetizer done");
    results();
  end
endmodule // tb_top
